// ### src/nsac_pkg.sv
// Package for the non-secure access control register block.
// Assumes a system-coprocessor move port delivers decoded opcode fields.
package nsac_pkg;
	// Coprocessor move encoding that selects this register
	localparam logic [2:0] NSAC_OPC1 = 3'h0;
	localparam logic [3:0] NSAC_CRN = 4'h1;
	localparam logic [3:0] NSAC_CRM = 4'h1;
	localparam logic [2:0] NSAC_OPC2 = 3'h2;
	// Field positions
	localparam int NSAC_COH_POS = 18;
	localparam int NSAC_L2E_POS = 17;
	localparam int NSAC_SIMD_POS = 15;
	localparam int NSAC_NS_COPROC_ELEVEN_ENABLE_POS = 11;
	localparam int NSAC_NS_COPROC_TEN_ENABLE_POS = 10;
	// Reset value of every stored field
	localparam logic NSAC_FIELD_RST = 1'h0;
	localparam logic [31:0] NSAC_ZERO = 32'h0;
	// One coprocessor move request
	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] opc1;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [2:0] opc2;
		logic [31:0] wdata;
	} nsac_req_t;
	// Processor state seen by the block
	typedef struct packed {
		logic nonsecure;
		logic pl1_or_higher;
	} nsac_ctx_t;
	// Gate outputs toward the other control registers
	typedef struct packed {
		logic coh_write_ok;
		logic l2_err_write_ok;
		logic simd_force;
		logic ns_coproc_eleven_enable_deny;
		logic ns_coproc_ten_enable_deny;
	} nsac_gate_t;
endpackage

// ### src/nsac_reg.sv
// Non-secure access control register and the gates it drives.
// Assumes requests and processor state come from logic on MCLK_I.
// Assumes CTX_I already reflects the mode of the instruction in flight.
// The gated registers live elsewhere; this block only steers them.
// How it works
// RQ1: Coherency enable zero blocks non-secure auxiliary writes
// RQ2: Enabled: only coherency participation bit writable
// RQ3: L2 enable zero blocks non-secure L2 control writes
// RQ4: Enabled: only L2 async error bits writable
// RQ5: SIMD disable forces non-secure SIMD bit one
// RQ6: FPU without SIMD: SIMD disable reads one
// RQ7: No FPU nor SIMD: SIMD field reads zero
// RQ8: Coprocessor eleven disabled: non-secure access undefined
// RQ9: Coprocessor ten disabled: non-secure access undefined
// RQ10: Disabled: access control field reads zero, locked
// RQ11: Enabled coprocessors reachable from both states
// RQ12: No FPU nor SIMD: enables read zero
// RQ13: Software keeps both coprocessor enables equal
// RQ14: Selected by opcode1 0, c1, c1, opcode2 2
// RQ15: Privileged only; writable secure, read-only non-secure
// RQ16: Reserved bits hold nothing, read zero
`timescale 1ns/1ps
module nsac_reg #(
	parameter bit HAS_FPU = 1'b1, // Floating-point hardware present
	parameter bit HAS_SIMD = 1'b1 // SIMD extension present
) (
	input wire logic MCLK_I,
	input wire logic RST_B_I,
	input wire logic CE_I,
	input wire nsac_pkg::nsac_req_t REQ_I,
	input wire nsac_pkg::nsac_ctx_t CTX_I,
	input wire logic NS_COPROC_ELEVEN_ENABLE_ACCESS_I,
	input wire logic NS_COPROC_TEN_ENABLE_ACCESS_I,
	output logic [31:0] RDATA_O,
	output logic RVALID_O,
	output logic ACC_FAULT_O,
	output logic UNDEF_O,
	output nsac_pkg::nsac_gate_t GATE_O
);
	// Reset synchroniser; first stage is read only by the second
	// Release is delayed two edges so no field leaves reset on a runt pulse
	// The synchroniser ignores CE_I so that a reset always completes
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// Stored fields; reserved bits have no flops at all
	logic coh_q; // Coherency write enable
	logic l2e_q; // L2 error write enable
	logic simd_q; // Non-secure SIMD disable
	logic ns_coproc_eleven_enable_q; // Coprocessor eleven enable
	logic ns_coproc_ten_enable_q; // Coprocessor ten enable
	logic coh_d; // Next coherency write enable
	logic l2e_d; // Next L2 error write enable
	logic simd_d; // Next SIMD disable
	logic ns_coproc_eleven_enable_d; // Next coprocessor eleven enable
	logic ns_coproc_ten_enable_d; // Next coprocessor ten enable

	// Decode of the move encoding
	// The encoding is compared in full; a near miss belongs to another register
	// and produces neither data nor a fault here
	wire sel = REQ_I.valid && REQ_I.opc1 == nsac_pkg::NSAC_OPC1 && REQ_I.crn == nsac_pkg::NSAC_CRN
		&& REQ_I.crm == nsac_pkg::NSAC_CRM && REQ_I.opc2 == nsac_pkg::NSAC_OPC2; // RQ14
	// Unprivileged access faults; non-secure writes fault as read-only
	// Non-secure software may look but never touch; a refused write costs
	// one fault pulse and leaves every field as it was
	wire priv_ok = CTX_I.pl1_or_higher; // RQ15
	wire wr_ok = sel && REQ_I.write && priv_ok && !CTX_I.nonsecure; // RQ15
	wire rd_ok = sel && !REQ_I.write && priv_ok; // RQ15
	wire fault = sel && (!priv_ok || (REQ_I.write && CTX_I.nonsecure)); // RQ15
	// Which fields can hold state in this configuration
	wire cp_impl = HAS_FPU || HAS_SIMD; // RQ12
	wire simd_impl = HAS_FPU && HAS_SIMD; // RQ6
	wire [31:0] wd = REQ_I.wdata;

	// Next values; unimplemented fields stay at reset value
	// Only a secure privileged write moves a field; everything else holds
	// Coherency and L2 enables exist in every configuration
	// The SIMD field is stored only when both units are present
	assign coh_d = wr_ok ? wd[nsac_pkg::NSAC_COH_POS] : coh_q;
	assign l2e_d = wr_ok ? wd[nsac_pkg::NSAC_L2E_POS] : l2e_q;
	assign simd_d = (wr_ok && simd_impl) ? wd[nsac_pkg::NSAC_SIMD_POS] : simd_q;
	assign ns_coproc_eleven_enable_d = (wr_ok && cp_impl) ? wd[nsac_pkg::NSAC_NS_COPROC_ELEVEN_ENABLE_POS] : ns_coproc_eleven_enable_q; // RQ12
	assign ns_coproc_ten_enable_d = (wr_ok && cp_impl) ? wd[nsac_pkg::NSAC_NS_COPROC_TEN_ENABLE_POS] : ns_coproc_ten_enable_q; // RQ12

	// Visible field values
	// With no FPU and no SIMD the SIMD field is unknown; zero is returned
	wire simd_vis = simd_impl ? simd_q : (HAS_FPU ? 1'b1 : 1'b0); // RQ6 RQ7
	wire ns_coproc_eleven_enable_vis = cp_impl & ns_coproc_eleven_enable_q; // RQ12
	wire ns_coproc_ten_enable_vis = cp_impl & ns_coproc_ten_enable_q; // RQ12
	wire [31:0] rd_word = {13'h0, coh_q, l2e_q, 1'b0, simd_vis, 3'h0,
		ns_coproc_eleven_enable_vis, ns_coproc_ten_enable_vis, 10'h0}; // RQ16

	// Gates toward other registers; secure state is never restricted
	// Gates are levels recomputed every cycle, so a change of security
	// state reaches the other registers one cycle later
	wire ns = CTX_I.nonsecure;
	nsac_pkg::nsac_gate_t gate_d;
	assign gate_d.coh_write_ok = !ns || coh_q; // RQ1 RQ2
	assign gate_d.l2_err_write_ok = !ns || l2e_q; // RQ3 RQ4
	assign gate_d.simd_force = ns && simd_vis; // RQ5 RQ6
	assign gate_d.ns_coproc_eleven_enable_deny = ns && !ns_coproc_eleven_enable_vis; // RQ10 RQ11
	assign gate_d.ns_coproc_ten_enable_deny = ns && !ns_coproc_ten_enable_vis; // RQ10 RQ11
	// Non-secure use of a disabled coprocessor is undefined
	// Unequal enables are left to software; each trap uses its own field
	wire undef_d = ns && ((NS_COPROC_ELEVEN_ENABLE_ACCESS_I && !ns_coproc_eleven_enable_vis)
		|| (NS_COPROC_TEN_ENABLE_ACCESS_I && !ns_coproc_ten_enable_vis)); // RQ8 RQ9

	// Field storage, frozen while CE_I is low
	// Reserved positions have no flops, so they cannot pick up stray writes
	// Holding on CE_I low keeps fields and outputs in step with each other
	always_ff @(posedge MCLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			coh_q <= nsac_pkg::NSAC_FIELD_RST;
			l2e_q <= nsac_pkg::NSAC_FIELD_RST;
			simd_q <= nsac_pkg::NSAC_FIELD_RST;
			ns_coproc_eleven_enable_q <= nsac_pkg::NSAC_FIELD_RST;
			ns_coproc_ten_enable_q <= nsac_pkg::NSAC_FIELD_RST;
		end else if (CE_I) begin
			coh_q <= coh_d;
			l2e_q <= l2e_d;
			simd_q <= simd_d;
			ns_coproc_eleven_enable_q <= ns_coproc_eleven_enable_d;
			ns_coproc_ten_enable_q <= ns_coproc_ten_enable_d;
		end
	end

	// Registered outputs; gates lag the fields by one cycle
	// RDATA_O returns to zero between reads so a stale word is never seen
	// Faults and traps are pulses: one cycle per offending request
	always_ff @(posedge MCLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			RDATA_O <= nsac_pkg::NSAC_ZERO;
			RVALID_O <= 1'b0;
			ACC_FAULT_O <= 1'b0;
			UNDEF_O <= 1'b0;
			GATE_O <= '0;
		end else if (CE_I) begin
			RDATA_O <= rd_ok ? rd_word : nsac_pkg::NSAC_ZERO;
			RVALID_O <= rd_ok;
			ACC_FAULT_O <= fault;
			UNDEF_O <= undef_d;
			GATE_O <= gate_d;
		end
	end

	// Checks
	// Named steps of a register access, shared by the checks below
	sequence s_sec_write;
		CE_I && wr_ok;
	endsequence
	// An accepted privileged read
	sequence s_ok_read;
		CE_I && rd_ok;
	endsequence
	// A request that must be refused with a fault
	sequence s_refused;
		CE_I && fault;
	endsequence
	// Any enabled cycle spent in non-secure state
	sequence s_ns_cycle;
		CE_I && ns;
	endsequence

	// A non-secure write must leave the coherency field alone and raise a fault
	a_ns_write_blocked: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ15
		(CE_I && sel && REQ_I.write && ns) |=> $stable(coh_q) && ACC_FAULT_O)
		else $error("non-secure write changed register");
	// Gate levels follow the previous cycle's state and fields
	a_coh_gate: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ1 RQ2
		CE_I |=> GATE_O.coh_write_ok == (!$past(ns) || $past(coh_q)))
		else $error("coherency gate wrong");
	a_l2_gate: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ3 RQ4
		CE_I |=> GATE_O.l2_err_write_ok == (!$past(ns) || $past(l2e_q)))
		else $error("l2 gate wrong");
	a_simd_force: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ5 RQ6
		(CE_I && ns && simd_vis) |=> GATE_O.simd_force)
		else $error("simd not forced");
	// Coprocessor traps in non-secure state
	a_cp_undef: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ8
		(CE_I && ns && NS_COPROC_ELEVEN_ENABLE_ACCESS_I && !ns_coproc_eleven_enable_vis) |=> UNDEF_O)
		else $error("ns_coproc_eleven_enable access not undefined");
	a_ns_coproc_ten_enable_undef: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ9
		(CE_I && ns && NS_COPROC_TEN_ENABLE_ACCESS_I && !ns_coproc_ten_enable_vis) |=> UNDEF_O)
		else $error("ns_coproc_ten_enable access not undefined");
	a_cp_deny: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ11 RQ10
		(CE_I && !ns) |=> !GATE_O.ns_coproc_eleven_enable_deny && !GATE_O.ns_coproc_ten_enable_deny)
		else $error("secure coprocessor denied");
	// Secure state never traps, whatever the enables hold
	a_secure_no_undef: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ11
		(CE_I && !ns) |=> !UNDEF_O)
		else $error("secure coprocessor access trapped");
	// Non-secure deny gates track the visible enables
	a_ns_cp_deny: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ10
		s_ns_cycle |=> GATE_O.ns_coproc_eleven_enable_deny == !$past(ns_coproc_eleven_enable_vis)
		&& GATE_O.ns_coproc_ten_enable_deny == !$past(ns_coproc_ten_enable_vis))
		else $error("non-secure deny gate wrong");
	// Only the five field positions may ever read as one
	a_reserved_zero: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ16
		RVALID_O |-> (RDATA_O & 32'hfff9_73ff) == 32'h0)
		else $error("reserved bit read nonzero");
	// A secure write lands in the enables on the next edge
	a_secure_write: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ14
		s_sec_write |=> coh_q == $past(wd[nsac_pkg::NSAC_COH_POS])
		&& l2e_q == $past(wd[nsac_pkg::NSAC_L2E_POS]))
		else $error("secure write not stored");
	// Coprocessor enables store only where the units exist
	a_cp_stored: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ12
		s_sec_write |=> ns_coproc_eleven_enable_q == ($past(wd[nsac_pkg::NSAC_NS_COPROC_ELEVEN_ENABLE_POS]) && cp_impl)
		&& ns_coproc_ten_enable_q == ($past(wd[nsac_pkg::NSAC_NS_COPROC_TEN_ENABLE_POS]) && cp_impl))
		else $error("coprocessor enable stored wrongly");
	// An accepted read answers with the live coherency field
	a_read_answer: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ14
		s_ok_read |=> RVALID_O && RDATA_O[nsac_pkg::NSAC_COH_POS] == $past(coh_q))
		else $error("read answer wrong");
	// A refused access brings a fault and no data
	a_fault_no_data: assert property (@(posedge MCLK_I) disable iff (!rst_n_q) // RQ15
		s_refused |=> ACC_FAULT_O && !RVALID_O && RDATA_O == nsac_pkg::NSAC_ZERO)
		else $error("refused access returned data");
endmodule

// ### verif/nonsecure_access_control_reg_tb.sv
// Self-checking bench for the non-secure access control register.
// Assumes nsac_pkg and nsac_reg are compiled first; bench drives all ports.
`timescale 1ns/1ps
module nonsecure_access_control_reg_tb;
	logic MCLK_I = 1'b0, RST_B_I = 1'b0, CE_I = 1'b1;
	logic NS_COPROC_ELEVEN_ENABLE_ACCESS_I = 1'b0, NS_COPROC_TEN_ENABLE_ACCESS_I = 1'b0;
	nsac_pkg::nsac_req_t REQ_I = '0; // Idle request
	nsac_pkg::nsac_ctx_t CTX_I = '0; // Secure, unprivileged
	logic [31:0] RDATA_O;
	logic RVALID_O, ACC_FAULT_O, UNDEF_O;
	nsac_pkg::nsac_gate_t GATE_O;
	int err_count = 0, tests_run = 0;
	// 20 MHz clock
	always #25 MCLK_I = ~MCLK_I;
	nsac_reg uut (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .CE_I(CE_I), .REQ_I(REQ_I),
		.CTX_I(CTX_I), .NS_COPROC_ELEVEN_ENABLE_ACCESS_I(NS_COPROC_ELEVEN_ENABLE_ACCESS_I), .NS_COPROC_TEN_ENABLE_ACCESS_I(NS_COPROC_TEN_ENABLE_ACCESS_I),
		.RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .ACC_FAULT_O(ACC_FAULT_O),
		.UNDEF_O(UNDEF_O), .GATE_O(GATE_O));
	// Compare and count
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// One coprocessor move; outputs sampled just after the taking edge
	task automatic acc(input logic w, ns, pl, input logic [2:0] o2, input logic [31:0] d);
		@(posedge MCLK_I);
		REQ_I <= '{1'b1, w, nsac_pkg::NSAC_OPC1, nsac_pkg::NSAC_CRN, nsac_pkg::NSAC_CRM, o2, d};
		CTX_I <= '{ns, pl};
		@(posedge MCLK_I);
		REQ_I.valid <= 1'b0;
		#1;
	endtask
	// Read and judge the answer; a fault brings no data
	task automatic rd(input logic ns, pl, input logic [31:0] e, input logic f);
		acc(1'b0, ns, pl, nsac_pkg::NSAC_OPC2, 32'h0);
		chk("fault", ACC_FAULT_O, f);
		chk("rvalid", RVALID_O, !f);
		if (!f) chk("rdata", RDATA_O, e);
	endtask
	// Reset values are all zero
	task automatic t_reset();
		rd(1'b0, 1'b1, 32'h0, 1'b0);
	endtask
	// All-ones secure write keeps only the five fields; non-secure may read
	task automatic t_fields();
		acc(1'b1, 1'b0, 1'b1, nsac_pkg::NSAC_OPC2, 32'hffffffff);
		chk("wr fault", ACC_FAULT_O, 1'b0);
		rd(1'b0, 1'b1, 32'h00068c00, 1'b0);
		rd(1'b1, 1'b1, 32'h00068c00, 1'b0);
	endtask
	// Refused writes, unprivileged reads and foreign encodings
	task automatic t_refuse();
		acc(1'b1, 1'b1, 1'b1, nsac_pkg::NSAC_OPC2, 32'h0);
		chk("ns wr fault", ACC_FAULT_O, 1'b1);
		acc(1'b1, 1'b0, 1'b0, nsac_pkg::NSAC_OPC2, 32'h0);
		chk("upriv wr fault", ACC_FAULT_O, 1'b1);
		rd(1'b0, 1'b0, 32'h0, 1'b1);
		acc(1'b1, 1'b0, 1'b1, 3'h0, 32'h0);
		chk("other enc", {ACC_FAULT_O, RVALID_O}, 2'b00);
		rd(1'b0, 1'b1, 32'h00068c00, 1'b0);
	endtask
	// Gate levels and coprocessor traps in non-secure state
	task automatic t_gates(input logic v);
		acc(1'b1, 1'b0, 1'b1, nsac_pkg::NSAC_OPC2, v ? 32'h00068c00 : 32'h0);
		@(posedge MCLK_I);
		CTX_I <= '{1'b1, 1'b1};
		repeat (2) @(posedge MCLK_I);
		#1;
		chk("gates", GATE_O, v ? 5'b11100 : 5'b00011);
		@(posedge MCLK_I);
		NS_COPROC_ELEVEN_ENABLE_ACCESS_I <= 1'b1;
		@(posedge MCLK_I);
		NS_COPROC_ELEVEN_ENABLE_ACCESS_I <= 1'b0;
		#1;
		chk("undef ns_coproc_eleven_enable", UNDEF_O, !v);
		@(posedge MCLK_I);
		NS_COPROC_TEN_ENABLE_ACCESS_I <= 1'b1;
		@(posedge MCLK_I);
		NS_COPROC_TEN_ENABLE_ACCESS_I <= 1'b0;
		#1;
		chk("undef ns_coproc_ten_enable", UNDEF_O, !v);
	endtask
	// Counts, verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge MCLK_I);
		RST_B_I <= 1'b1;
		repeat (3) @(posedge MCLK_I);
		t_reset();
		t_fields();
		t_refuse();
		t_gates(1'b1);
		t_gates(1'b0);
		complete_run();
	end
	// Watchdog: the run needs well under 200 cycles
	initial begin
		#100us;
		err_count++;
		complete_run();
	end
endmodule
